// ---- design/lamp_ballast_mode_sequencer.sv ----
// Purpose: mode sequencing of a discharge-lamp ballast controller
// Assumes: comparator results arrive as levels synchronous to clk
// Notes: buck on-time regulation and power control live elsewhere
`timescale 1ns/1ps
`include "lamp_ballast_map.svh"

module lamp_ballast_mode_sequencer #(
  parameter int TICK_CYCLES = `IGNITION_TICK_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int BRIDGE_HALF_CYCLES = 1000000000 / (2 * `BRIDGE_FREQ_HZ * `CLK_PERIOD_NS),
  parameter logic [7:0] FAULT_LIMIT = `FAULT_LIMIT_DEFAULT,
  parameter logic [7:0] GOOD_LIMIT = `GOOD_LIMIT_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // start-up comparators
  input wire logic supplyAtStartupThreshold,
  input wire logic probeAboveHighLimit,
  input wire logic restartPinLow,
  // ignition detect comparator
  input wire logic probeBelowIgnitionLevel,
  // general mode comparators
  input wire logic voltageAboveLimitPin,
  input wire logic voltageBelowMinimum,
  input wire logic currentAboveLimitPin,
  // bridge gates
  output logic highGateA,
  output logic lowGateA,
  output logic highGateB,
  output logic lowGateB,
  // buck and strike
  output logic buckGate,
  output logic strikeOutput,
  // status
  output logic faultLatched,
  output lamp_ballast_pkg::mode_t mode
);
  import lamp_ballast_pkg::*;

  // ==========================================================
  // derived counts
  localparam int DEAD_CYCLES = (`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int ON_TICKS = (`STRIKE_ON_MS + `IGNITION_TICK_MS - 1) / `IGNITION_TICK_MS;
  localparam int TIMEOUT_TICKS = `IGNITION_TIMEOUT_S * 1000 / `IGNITION_TICK_MS;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam logic [31:0] HALF_LAST = 32'(BRIDGE_HALF_CYCLES - 1);
  localparam logic [7:0] DEAD_LOAD = 8'(DEAD_CYCLES);
  localparam logic [6:0] ON_LAST = 7'(ON_TICKS);
  localparam logic [10:0] TIMEOUT_LAST = 11'(TIMEOUT_TICKS);
  localparam logic [6:0] PERIOD_LAST = 7'(`STRIKE_PERIOD_TICKS - 1);

  // ==========================================================
  // state
  mode_t next_mode;
  logic [31:0] tickCount;
  logic [31:0] halfCount;
  logic [7:0] deadCount;
  logic bridgePhase;
  logic [6:0] phaseCount;
  logic [10:0] attemptTicks;
  logic [7:0] faultCount;
  logic [7:0] goodCount;
  logic prevAbnormal;

  // ==========================================================
  // mode decode
  wire inLockout = (mode == MODE_LOCKOUT);
  wire inIgnition = (mode == MODE_IGNITION);
  wire inGeneral = (mode == MODE_GENERAL);
  wire startOk = supplyAtStartupThreshold && probeAboveHighLimit && restartPinLow;
  wire timedOut = (attemptTicks == TIMEOUT_LAST);
  wire abnormal = voltageAboveLimitPin || voltageBelowMinimum || currentAboveLimitPin;
  wire faultEvent = inGeneral && abnormal && !prevAbnormal;
  wire faultLimitHit = faultEvent && (faultCount == FAULT_LIMIT - 8'h01);

  always_comb begin
    case (mode)
      MODE_LOCKOUT: next_mode = startOk ? MODE_IGNITION : MODE_LOCKOUT;
      MODE_IGNITION: begin
        if (timedOut) begin
          next_mode = MODE_FAULT;
        end else if (probeBelowIgnitionLevel) begin
          next_mode = MODE_GENERAL;
        end else begin
          next_mode = MODE_IGNITION;
        end
      end
      MODE_GENERAL: next_mode = faultLimitHit ? MODE_FAULT : MODE_GENERAL;
      MODE_FAULT: next_mode = MODE_FAULT;
      default: next_mode = MODE_LOCKOUT;
    endcase
    if (!supplyAtStartupThreshold) begin
      next_mode = MODE_LOCKOUT;
    end
  end

  wire enterIgnition = inLockout && (next_mode == MODE_IGNITION);
  wire running = (mode == MODE_IGNITION) || (mode == MODE_GENERAL);
  wire next_running = (next_mode == MODE_IGNITION) || (next_mode == MODE_GENERAL);

  // ==========================================================
  // ignition tick divider
  wire tick = running && (tickCount == TICK_LAST);
  // timer already zero on the edge into lockout
  wire [31:0] next_tickCount = (!next_running || enterIgnition || tick) ? 32'h0000_0000 : tickCount + 32'h0000_0001;
  wire [6:0] next_phaseCount = (!inIgnition) ? `PHASE_RESET : (tick ? phaseCount + 7'h01 : phaseCount);
  // judged on the phase shown next cycle, so strike and phase move together
  wire strikePatternOn = (next_phaseCount < ON_LAST);
  wire attemptStep = inIgnition && tick && !timedOut;
  wire [10:0] next_attemptTicks = (!inIgnition) ? `ATTEMPT_RESET : attemptTicks + {10'h000, attemptStep};

  // ==========================================================
  // bridge oscillator and dead-time
  wire toggle = running && (halfCount == HALF_LAST);
  wire [31:0] next_halfCount = (!running || toggle) ? 32'h0000_0000 : halfCount + 32'h0000_0001;
  wire next_bridgePhase = running ? (bridgePhase ^ toggle) : 1'b0;
  logic [7:0] next_deadCount;
  always_comb begin
    if (!next_running) begin
      next_deadCount = 8'h00;
    end else if (toggle) begin
      next_deadCount = DEAD_LOAD;
    end else if (deadCount != 8'h00) begin
      next_deadCount = deadCount - 8'h01;
    end else begin
      next_deadCount = 8'h00;
    end
  end
  wire deadActive = (deadCount != 8'h00);
  wire next_deadActive = (next_deadCount != 8'h00);
  wire gatesOn = next_running && !next_deadActive;

  // ==========================================================
  // general mode counters
  wire goodDone = inGeneral && tick && !abnormal && (goodCount == GOOD_LIMIT);
  logic [7:0] next_faultCount;
  logic [7:0] next_goodCount;
  always_comb begin
    if (inLockout) begin
      next_faultCount = `COUNT_RESET;
    end else if (faultEvent) begin
      next_faultCount = faultCount + 8'h01;
    end else if (goodDone) begin
      next_faultCount = `COUNT_RESET;
    end else begin
      next_faultCount = faultCount;
    end
    if (inLockout || abnormal || goodDone) begin
      next_goodCount = `COUNT_RESET;
    end else if (inGeneral && tick) begin
      next_goodCount = goodCount + 8'h01;
    end else begin
      next_goodCount = goodCount;
    end
  end

  wire next_buck = (next_mode == MODE_IGNITION) ||
                   ((next_mode == MODE_GENERAL) && !voltageAboveLimitPin && !currentAboveLimitPin);
  // strike only in ignition, low in dead-time and after ignition
  wire next_strike = (next_mode == MODE_IGNITION) && !enterIgnition && strikePatternOn &&
                     !next_deadActive;

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode <= MODE_LOCKOUT;
      tickCount <= 32'h0000_0000;
      phaseCount <= `PHASE_RESET;
      attemptTicks <= `ATTEMPT_RESET;
    end else begin
      mode <= next_mode;
      tickCount <= next_tickCount;
      phaseCount <= next_phaseCount;
      attemptTicks <= next_attemptTicks;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      halfCount <= 32'h0000_0000;
      deadCount <= 8'h00;
      bridgePhase <= 1'b0;
    end else begin
      halfCount <= next_halfCount;
      deadCount <= next_deadCount;
      bridgePhase <= next_bridgePhase;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      faultCount <= `COUNT_RESET;
      goodCount <= `COUNT_RESET;
      prevAbnormal <= 1'b0;
    end else begin
      faultCount <= next_faultCount;
      goodCount <= next_goodCount;
      prevAbnormal <= abnormal && inGeneral;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      highGateA <= 1'b0;
      lowGateB <= 1'b0;
      highGateB <= 1'b0;
      lowGateA <= 1'b0;
      buckGate <= 1'b0;
      strikeOutput <= 1'b0;
      faultLatched <= 1'b0;
    end else begin
      highGateA <= gatesOn && !next_bridgePhase;
      lowGateB <= gatesOn && !next_bridgePhase;
      highGateB <= gatesOn && next_bridgePhase;
      lowGateA <= gatesOn && next_bridgePhase;
      buckGate <= next_buck;
      strikeOutput <= next_strike;
      faultLatched <= (next_mode == MODE_FAULT);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_start_qualified: assert property (inLockout ##1 inIgnition |->
    $past(supplyAtStartupThreshold && probeAboveHighLimit && restartPinLow))
    else $error("ignition entered without start conditions");

  a_bridge_starts: assert property (inLockout ##1 inIgnition |->
    (highGateA && lowGateB && !highGateB && !lowGateA))
    else $error("bridge gates not active on turn-on");

  a_lockout_off: assert property (inLockout |->
    (!highGateA && !lowGateA && !highGateB && !lowGateB && !buckGate && !strikeOutput && tickCount == 32'h0000_0000))
    else $error("outputs or timer active in lockout");

  a_lockout_clear: assert property (inLockout ##1 inLockout |->
    (faultCount == 8'h00 && goodCount == 8'h00 && !faultLatched))
    else $error("counters or latch not cleared in lockout");

  a_timer_fresh: assert property (inLockout ##1 inIgnition |->
    (tickCount == 32'h0000_0000 && phaseCount == 7'h00 && attemptTicks == 11'h000))
    else $error("strike timer not fresh on entry");

  a_tick_divides: assert property (inIgnition && tick && next_mode == MODE_IGNITION |=>
    (phaseCount == $past(phaseCount) + 7'h01))
    else $error("pattern phase did not follow tick");

  a_pattern_on: assert property (inIgnition && !deadActive && phaseCount != 7'h00 &&
    $past(inIgnition) |-> (strikeOutput == (phaseCount < ON_LAST)))
    else $error("strike pattern wrong");

  a_timeout_fault: assert property (inIgnition && timedOut && supplyAtStartupThreshold |=>
    (mode == MODE_FAULT && faultLatched && !buckGate))
    else $error("ignition timeout did not latch fault");

  a_ignite_general: assert property (inIgnition && !timedOut && probeBelowIgnitionLevel &&
    supplyAtStartupThreshold |=> (inGeneral && !strikeOutput))
    else $error("ignition detect did not end strike");

  a_fault_count: assert property (faultEvent && !faultLimitHit && supplyAtStartupThreshold |=>
    (faultCount == $past(faultCount) + 8'h01))
    else $error("fault event not counted");

  a_dead_strike: assert property (deadActive |-> !strikeOutput && !highGateA && !highGateB)
    else $error("strike or gate active in dead-time");

  a_dead_length: assert property ($rose(deadActive) |-> deadActive[*8])
    else $error("dead-time too short");

  a_fault_stops: assert property (mode == MODE_FAULT |->
    (!highGateA && !lowGateA && !highGateB && !lowGateB && !strikeOutput))
    else $error("bridge active in fault mode");

  a_timeout_span: assert property (inIgnition && tick && !timedOut && next_mode == MODE_IGNITION |=>
    (attemptTicks == $past(attemptTicks) + 11'h001))
    else $error("attempt time not counted in every phase");

  c_ignition_entry: cover property (inLockout ##1 inIgnition);
  c_lamp_ignites: cover property (inIgnition ##1 inGeneral);
  c_fault_latched: cover property (inGeneral ##1 mode == MODE_FAULT);
  c_pattern_wraps: cover property (inIgnition && tick && phaseCount == PERIOD_LAST);

endmodule

// ---- design/lamp_ballast_map.svh ----
// Purpose: named constants of the lamp ballast mode sequencer
// Assumes: 100 MHz system clock
// Notes: times are kept in their own units, cycle counts derive from them
`ifndef LAMP_BALLAST_MAP_SVH
`define LAMP_BALLAST_MAP_SVH

// ==========================================================
// clock
`define CLK_PERIOD_NS 10
// ==========================================================
// strike timing
`define IGNITION_TICK_MS 666
`define STRIKE_ON_MS 21000
`define STRIKE_PERIOD_TICKS 128
`define IGNITION_TIMEOUT_S 1180
// ==========================================================
// bridge timing
`define DEAD_TIME_NS 1000
`define BRIDGE_FREQ_HZ 149
// ==========================================================
// general mode counting
`define FAULT_LIMIT_DEFAULT 8'h07
`define GOOD_LIMIT_DEFAULT 8'h0F
// ==========================================================
// reset values
`define PHASE_RESET 7'h00
`define ATTEMPT_RESET 11'h000
`define COUNT_RESET 8'h00

`endif

// ---- design/lamp_ballast_pkg.sv ----
// Purpose: types shared by the lamp ballast mode sequencer
// Assumes: nothing
// Notes: one-hot operating mode
package lamp_ballast_pkg;
  typedef enum logic [3:0] {
    MODE_LOCKOUT = 4'h1,
    MODE_IGNITION = 4'h2,
    MODE_GENERAL = 4'h4,
    MODE_FAULT = 4'h8
  } mode_t;
endpackage

// ---- dv/lamp_stage_model.sv ----
// Purpose: far-side lamp, strike switch and power stage model
// Assumes: lamp lights after a few strike cycles once allowed
// Notes: unlit lamp shows open-circuit probe levels
`timescale 1ns/1ps
module lamp_stage_model (
  // clock
  input wire logic clk,
  // device drive
  input wire logic strikeOutput,
  input wire logic bridgeOn,
  input wire logic buckGate,
  // scenario control
  input wire logic ignitable,
  input wire logic shortedProbe,
  // probe comparators
  output logic probeAboveHighLimit,
  output logic probeBelowIgnitionLevel
);
  // ==========================================
  // lamp state
  logic lit = 1'b0;
  logic [2:0] strikeRun = 3'h0;
  always_ff @(posedge clk) begin
    strikeRun <= (strikeOutput && ignitable) ? strikeRun + 3'h1 : 3'h0;
    if (strikeRun == 3'h5)
      lit <= 1'b1;
    else if (!buckGate && !bridgeOn)
      lit <= 1'b0;
  end
  assign probeAboveHighLimit = !lit && !shortedProbe;
  assign probeBelowIgnitionLevel = lit;
endmodule

// ---- dv/lamp_ballast_mode_sequencer_tb_top.sv ----
// Purpose: self-checking bench of the lamp ballast mode sequencer
// Assumes: shortened tick (4 clocks) and bridge half period (300 clocks)
// Notes: expected results queued by the driver, compared by a watcher
`timescale 1ns/1ps
module lamp_ballast_mode_sequencer_tb_top;
  import lamp_ballast_pkg::*;
  // ==========================================
  // signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic supply = 1'b0;
  logic restart = 1'b0;
  logic ignitable = 1'b0;
  logic shorted = 1'b0;
  logic vAbove = 1'b0;
  logic vBelow = 1'b0;
  logic iAbove = 1'b0;
  logic probeAbove, probeBelow, hiA, loA, hiB, loB, buck, strike, fault, bridgeOn;
  mode_t mode;
  logic [7:0] obs;
  logic [7:0] expQ[$];
  logic [7:0] maskQ[$];
  event chk;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int sel;
  assign bridgeOn = hiA | loA | hiB | loB;
  assign obs = {mode, fault, buck, strike, bridgeOn};
  // ==========================================
  // design and far side
  lamp_ballast_mode_sequencer #(.TICK_CYCLES(4), .BRIDGE_HALF_CYCLES(300)) DUT (
    .clk(clk), .rstn(rstn), .supplyAtStartupThreshold(supply), .probeAboveHighLimit(probeAbove),
    .restartPinLow(restart), .probeBelowIgnitionLevel(probeBelow), .voltageAboveLimitPin(vAbove),
    .voltageBelowMinimum(vBelow), .currentAboveLimitPin(iAbove), .highGateA(hiA), .lowGateA(loA),
    .highGateB(hiB), .lowGateB(loB), .buckGate(buck), .strikeOutput(strike), .faultLatched(fault),
    .mode(mode));
  lamp_stage_model lamp (.clk(clk), .strikeOutput(strike), .bridgeOn(bridgeOn), .buckGate(buck),
    .ignitable(ignitable), .shortedProbe(shorted), .probeAboveHighLimit(probeAbove),
    .probeBelowIgnitionLevel(probeBelow));
  // ==========================================
  // clock, watchdog and watchers
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  always @(chk) begin
    comparisons++;
    if ((obs & maskQ[0]) !== (expQ[0] & maskQ[0])) begin
      mismatches++;
      $display("FAIL t=%0t exp=%h got=%h", $time, expQ[0], obs);
    end
    void'(expQ.pop_front());
    void'(maskQ.pop_front());
  end
  always @(negedge clk) begin
    comparisons++;
    if ((strike && !((hiA && loB) || (hiB && loA))) || (hiA && loA) || (hiB && loB) ||
        (mode === MODE_LOCKOUT && (bridgeOn || buck))) begin
      mismatches++;
      $display("FAIL t=%0t exp=%h got=%h", $time, 8'h00, obs);
    end
  end
  // ==========================================
  // tasks
  task automatic note(input logic [7:0] ex, input logic [7:0] mk);
    @(negedge clk);
    expQ.push_back(ex);
    maskQ.push_back(mk);
    ->chk;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // scenarios
  initial begin
    void'($urandom(32'h3bf2_e3e4));
    tick(5);
    rstn <= 1'b1;
    note(8'h10, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      supply <= (k != 0);
      restart <= (k != 1);
      shorted <= (k == 2);
      vBelow <= 1'($urandom % 2);
      tick(3);
      note(8'h10, 8'hFF);
    end
    @(posedge clk);
    supply <= 1'b1;
    restart <= 1'b1;
    shorted <= 1'b0;
    vBelow <= 1'b0;
    @(posedge clk);
    note(8'h25, 8'hFF);
    tick(64);
    note(8'h27, 8'hFF);
    tick(136);
    note(8'h25, 8'hFF);
    tick(150);
    note(8'h24, 8'hFF);
    tick(226);
    note(8'h27, 8'hFE);
    tick(6424);
    note(8'h24, 8'hFE);
    tick(200);
    note(8'h88, 8'hFF);
    @(posedge clk);
    supply <= 1'b0;
    tick(2);
    note(8'h10, 8'hFF);
    @(posedge clk);
    supply <= 1'b1;
    ignitable <= 1'b1;
    for (int k = 0; k < 100 && mode !== MODE_GENERAL; k++) @(posedge clk);
    note(8'h44, 8'hFE);
    for (int k = 0; k < 7; k++) begin
      sel = $urandom % 3;
      @(posedge clk);
      vAbove <= (sel == 0);
      vBelow <= (sel == 1);
      iAbove <= (sel == 2);
      tick(2);
      note(k < 6 ? {4'h4, 1'b0, sel == 1, 2'b00} : 8'h88, k < 6 ? 8'hFE : 8'hFF);
      @(posedge clk);
      vAbove <= 1'b0;
      vBelow <= 1'b0;
      iAbove <= 1'b0;
      tick(1);
    end
    tally_and_finish();
  end
endmodule
